// file: dv/keyboard_pin_interrupt_properties.sv
// port checker for the keyboard pin interrupt block
`timescale 1ns/1ps
module keyboard_pin_checker #(parameter NPINS = 6) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire [NPINS-1:0] keyboard_input_pins,
    input wire [NPINS-1:0] pullup_en,
    input wire [NPINS-1:0] pulldown_en,
    input wire [NPINS-1:0] pin_force_input,
    input wire keyboard_irq,
    input wire irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready too long");
    a_ack_reads_zero: assert property (pready && !pwrite && paddr == 12'h000 |-> !prdata[2]) else $error("ack");
    a_pull_exclusive: assert property (!(|(pullup_en & pulldown_en))) else $error("both pulls");
    a_pull_on_enable: assert property ((pullup_en | pulldown_en) == pin_force_input) else $error("pull");
    a_reset_clears: assert property ($rose(presetn) |-> !keyboard_irq && !irq) else $error("reset");
    a_irq_needs_enable: assert property ($rose(keyboard_irq) |-> |pin_force_input) else $error("enable");
    // an edge must have been seen stable for two edges, or the synchroniser is missing
    a_pins_synced: assert property ($rose(keyboard_irq) |-> $past(keyboard_input_pins, 1)
        == $past(keyboard_input_pins, 2)) else $error("sync");
endmodule // keyboard_pin_checker
bind keyboard_pin_interrupt keyboard_pin_checker #(.NPINS(NPINS)) u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .keyboard_input_pins, .pullup_en, .pulldown_en, .pin_force_input,
    .keyboard_irq, .irq);

// file: dv/keyboard_switch_model.sv
// key switches on the keyboard pins, resolved against the pull devices
`timescale 1ns/1ps
module keyboard_switch_model (
    input wire [5:0] press,
    input wire [5:0] pulldown_en,
    output wire [5:0] pins
);
    // a pressed key shorts the pin to the rail opposite its pull; open unpulled pins read high
    assign pins = ~(press ^ pulldown_en);
endmodule // keyboard_switch_model

// file: dv/test_keyboard_pin_interrupt.sv
// register-level testbench of the keyboard pin interrupt block
`timescale 1ns/1ps
module test_keyboard_pin_interrupt;
    reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg vector_fetch_ack = 1'b0, debug_break = 1'b0, last_err;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0, rdata;
    reg [5:0] press = 6'h00;
    wire [31:0] prdata;
    wire pready, pslverr, keyboard_irq, irq;
    wire [5:0] pins, pullup_en, pulldown_en, pin_force_input;
    int n_errors = 0, comparisons = 0;
    always #20 pclk = ~pclk;
    keyboard_pin_interrupt u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .keyboard_input_pins(pins), .vector_fetch_ack, .debug_break, .pullup_en,
        .pulldown_en, .pin_force_input, .keyboard_irq, .irq);
    keyboard_switch_model u_sw (.press(press), .pulldown_en(pulldown_en), .pins(pins));
    task end_of_test;
        if (n_errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    // one idle cycle after each transfer so no strobe is driven twice in a step
    task xfer(input w, input [11:0] a, input [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        last_err = pslverr;
        rdata = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input [11:0] a, input [31:0] d); xfer(1'b1, a, d); endtask
    task rd(input [11:0] a, input [31:0] e); xfer(1'b0, a, 32'h0); chk($sformatf("reg %h", a), e, rdata); endtask
    task w(input int k); repeat (k) @(posedge pclk); endtask
    initial
    begin
        w(4);
        presetn <= 1'b1;
        w(1);
        rd(12'h000, 32'h0);
        rd(12'h004, 32'h0);
        rd(12'h020, 32'h0);
        chk("pslverr", 32'h1, last_err);
        wr(12'h008, 32'h02);
        wr(12'h004, 32'h43);
        wr(12'h014, 32'h01);
        rd(12'h004, 32'h43);
        chk("pin_force_input", 32'h03, pin_force_input);
        chk("pullup_en", 32'h01, pullup_en);
        chk("pulldown_en", 32'h02, pulldown_en);
        press <= 6'h01;
        w(8);
        chk("keyboard_irq", 32'h1, keyboard_irq);
        chk("irq", 32'h1, irq);
        rd(12'h000, 32'h8);
        wr(12'h000, 32'h4);
        rd(12'h000, 32'h0);
        press <= 6'h03;
        w(8);
        rd(12'h000, 32'h0);
        wr(12'h010, 32'h3);
        wr(12'h014, 32'h0);
        chk("irq", 32'h0, irq);
        press <= 6'h00;
        w(8);
        wr(12'h000, 32'h2);
        press <= 6'h02;
        w(8);
        chk("keyboard_irq", 32'h0, keyboard_irq);
        rd(12'h000, 32'hA);
        vector_fetch_ack <= 1'b1;
        w(1);
        vector_fetch_ack <= 1'b0;
        w(1);
        rd(12'h000, 32'h2);
        press <= 6'h00;
        w(8);
        wr(12'h010, 32'h3);
        debug_break <= 1'b1;
        press <= 6'h01;
        w(8);
        wr(12'h000, 32'h6);
        rd(12'h000, 32'hA);
        wr(12'h010, 32'h1);
        rd(12'h010, 32'h1);
        wr(12'h00C, 32'h1);
        wr(12'h000, 32'h6);
        rd(12'h000, 32'h2);
        debug_break <= 1'b0;
        wr(12'h00C, 32'h0);
        rd(12'h000, 32'h2);
        press <= 6'h00;
        w(8);
        wr(12'h000, 32'h1);
        press <= 6'h01;
        w(8);
        wr(12'h000, 32'h5);
        rd(12'h000, 32'h9);
        press <= 6'h00;
        w(8);
        rd(12'h000, 32'h9);
        wr(12'h000, 32'h5);
        rd(12'h000, 32'h1);
        press <= 6'h01;
        w(8);
        presetn <= 1'b0;
        w(1);
        presetn <= 1'b1;
        w(1);
        rd(12'h000, 32'h0);
        end_of_test();
    end
    initial
    begin
        #100000;
        n_errors++;
        end_of_test();
    end
endmodule // test_keyboard_pin_interrupt

// file: hdl/keyboard_pin_interrupt.v
// keyboard pin interrupt block with apb register slave
`timescale 1ns/1ps
`include "keyboard_pin_interrupt_defines.vh"
module keyboard_pin_interrupt #(
    parameter NPINS = 6
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [NPINS-1:0] keyboard_input_pins,
    input wire vector_fetch_ack,
    input wire debug_break,
    output reg [NPINS-1:0] pullup_en,
    output reg [NPINS-1:0] pulldown_en,
    output reg [NPINS-1:0] pin_force_input,
    output reg keyboard_irq,
    output reg irq
);
    reg [NPINS-1:0] sync1_ff, sync2_ff, sync3_ff;
    reg [NPINS-1:0] pin_ff;
    reg mask_ff, sens_ff, latch_ff, break_clear_enable_ff, awu_ff;
    reg [NPINS-1:0] enable_ff, polarity_ff;
    reg [1:0] sts_ff, imask_ff;
    reg [NPINS-1:0] prev_asserted_ff;
    wire [NPINS-1:0] asserted;
    wire [NPINS-1:0] rising_act;
    wire any_asserted;
    wire any_edge;
    wire other_asserted;
    wire setup;
    wire wr;
    wire rd;
    wire clear_ok;
    wire sw_ack;
    wire ack;
    reg nxt_latch;
    reg [31:0] nxt_prdata;
    reg nxt_err;

    function hit;
        input [11:0] a;
        input [11:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    assign setup = psel & ~penable;
    // writes land at the access edge where pready is sampled high
    assign wr = psel & penable & pready & pwrite;
    assign rd = setup & ~pwrite;
    // status clears allowed outside break or when break clear is enabled
    assign clear_ok = ~debug_break | break_clear_enable_ff;
    assign sw_ack = wr & hit(paddr, `KBD_OFS_STATUS_CONTROL) & pwdata[`KBD_BIT_ACK];
    assign ack = (sw_ack & clear_ok) | vector_fetch_ack;

    // a change counts only once stages two and three agree
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_ff <= {NPINS{1'b0}};
            sync2_ff <= {NPINS{1'b0}};
            sync3_ff <= {NPINS{1'b0}};
            pin_ff <= {NPINS{1'b0}};
        end
        else
        begin
            sync1_ff <= keyboard_input_pins;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            if (sync2_ff == sync3_ff)
                pin_ff <= sync3_ff;
        end
    end

    // polarity per pin, gated by per-pin enable; awu bit takes no part
    assign asserted = enable_ff & ~(pin_ff ^ polarity_ff);
    assign rising_act = asserted & ~prev_asserted_ff;
    assign any_asserted = |asserted;
    assign any_edge = |rising_act;
    // an edge is lost if another enabled pin was already asserted
    assign other_asserted = |(prev_asserted_ff & ~rising_act);

    always @*
    begin
        nxt_latch = latch_ff;
        if (any_edge & ~other_asserted)
            nxt_latch = 1'b1;
        if (ack)
            nxt_latch = 1'b0;
        // in level mode a held pin keeps the request alive
        if (sens_ff & any_asserted)
            nxt_latch = 1'b1;
    end

    always @*
    begin
        nxt_prdata = 32'h0000_0000;
        nxt_err = 1'b0;
        if (hit(paddr, `KBD_OFS_STATUS_CONTROL))
        begin
            nxt_prdata[`KBD_BIT_PENDING] = latch_ff;
            nxt_prdata[`KBD_BIT_MASK] = mask_ff;
            nxt_prdata[`KBD_BIT_SENS] = sens_ff; // ack reads zero
        end
        else if (hit(paddr, `KBD_OFS_PIN_ENABLE))
            nxt_prdata[7:0] = {1'b0, awu_ff, enable_ff[5:0]};
        else if (hit(paddr, `KBD_OFS_PIN_POLARITY))
            nxt_prdata[7:0] = {2'b00, polarity_ff[5:0]};
        else if (hit(paddr, `KBD_OFS_BREAK_CONTROL))
            nxt_prdata[`KBD_BIT_BREAK_CLEAR_ENABLE] = break_clear_enable_ff;
        else if (hit(paddr, `KBD_OFS_IRQ_STATUS))
            nxt_prdata[1:0] = sts_ff;
        else if (hit(paddr, `KBD_OFS_IRQ_MASK))
            nxt_prdata[1:0] = imask_ff;
        else
            nxt_err = 1'b1;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask_ff <= 1'b0;
            sens_ff <= 1'b0;
            latch_ff <= 1'b0;
            break_clear_enable_ff <= 1'b0;
            awu_ff <= 1'b0;
            enable_ff <= {NPINS{1'b0}};
            polarity_ff <= {NPINS{1'b0}};
            prev_asserted_ff <= {NPINS{1'b0}};
            sts_ff <= 2'b00;
            imask_ff <= 2'b00;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            pullup_en <= {NPINS{1'b0}};
            pulldown_en <= {NPINS{1'b0}};
            pin_force_input <= {NPINS{1'b0}};
            keyboard_irq <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            prev_asserted_ff <= asserted;
            latch_ff <= nxt_latch;
            // no wait state: answer in the cycle after setup
            pready <= setup;
            pslverr <= setup & nxt_err;
            if (rd)
                prdata <= nxt_prdata;
            if (wr & hit(paddr, `KBD_OFS_STATUS_CONTROL))
            begin
                mask_ff <= pwdata[`KBD_BIT_MASK];
                sens_ff <= pwdata[`KBD_BIT_SENS];
            end
            if (wr & hit(paddr, `KBD_OFS_PIN_ENABLE))
            begin
                enable_ff <= pwdata[NPINS-1:0];
                awu_ff <= pwdata[`KBD_BIT_AWU];
            end
            if (wr & hit(paddr, `KBD_OFS_PIN_POLARITY))
                polarity_ff <= pwdata[NPINS-1:0];
            if (wr & hit(paddr, `KBD_OFS_BREAK_CONTROL))
                break_clear_enable_ff <= pwdata[`KBD_BIT_BREAK_CLEAR_ENABLE];
            if (wr & hit(paddr, `KBD_OFS_IRQ_MASK))
                imask_ff <= pwdata[1:0];
            // set wins over write-one clear; clear blocked in protected break
            sts_ff[0] <= (sts_ff[0] & ~(wr & clear_ok & hit(paddr, `KBD_OFS_IRQ_STATUS) & pwdata[0]))
                | (nxt_latch & ~latch_ff);
            sts_ff[1] <= (sts_ff[1] & ~(wr & clear_ok & hit(paddr, `KBD_OFS_IRQ_STATUS) & pwdata[1]))
                | (latch_ff & ~nxt_latch);
            irq <= |(sts_ff & imask_ff);
            pullup_en <= enable_ff & ~polarity_ff;
            pulldown_en <= enable_ff & polarity_ff;
            pin_force_input <= enable_ff;
            keyboard_irq <= nxt_latch & ~mask_ff;
        end
    end
endmodule // keyboard_pin_interrupt

// file: hdl/keyboard_pin_interrupt_defines.vh
// register map, field positions and reset values of the keyboard pin interrupt block
// Overview of operation
// - break clear enabled lets writes clear status
// - break clear disabled: break accesses keep status
// - two-step clears hold through protected break
// - all enabled pins share one interrupt request latch
// - enabled pin gets pullup or pulldown by polarity
// - pending flag read-only, shows latch
// - acknowledge write-one clears latch, reads zero
// - mask bit blocks keyboard_irq, not irq, when set
// - sensitivity bit selects edge-and-level or edge-only
// - per-pin enable lets pin latch requests
// - per-pin polarity selects high/rising or low/falling
// - auto-wakeup enable bit ignored by detection
// - edge-only: edge ignored if other pin asserted
// - level mode: clear needs pins idle and acknowledge
// - edge-only: acknowledge clears latch at once
// - reset clears request and sensitivity bit
`ifndef KEYBOARD_PIN_INTERRUPT_DEFINES_VH
`define KEYBOARD_PIN_INTERRUPT_DEFINES_VH
`define KBD_OFS_STATUS_CONTROL 12'h000
`define KBD_OFS_PIN_ENABLE 12'h004
`define KBD_OFS_PIN_POLARITY 12'h008
`define KBD_OFS_BREAK_CONTROL 12'h00C
`define KBD_OFS_IRQ_STATUS 12'h010
`define KBD_OFS_IRQ_MASK 12'h014
`define KBD_BIT_PENDING 3
`define KBD_BIT_ACK 2
`define KBD_BIT_MASK 1
`define KBD_BIT_SENS 0
`define KBD_BIT_AWU 6
`define KBD_BIT_BREAK_CLEAR_ENABLE 0
`define KBD_RST_STATUS_CONTROL 8'h00
`define KBD_RST_PIN_ENABLE 8'h00
`define KBD_RST_PIN_POLARITY 8'h00
`endif
